// file: hdl/sesp_core.v
// Serial EEPROM slave: pin sampling, command sequencing, array,
// write buffering and the self-timed write cycle.
// Assumes a 50 MHz clk_i; all serial pins are asynchronous to it.
`timescale 1ns/1ns
`include "sesp_regs.vh"

// Notes on behaviour
// - Input bits are taken on each rising serial clock edge.
// - Output bits change only after falling serial clock edges.
// - Deselected: output line floats.
// - Deselect enters standby; a running write cycle still completes.
// - Chip select low selects the device, ready for a command.
// - No instruction accepted before a first chip select falling edge.
// - Write-protect pin, while srwd is set, locks the protection settings against change.
// - Pause suspends the transfer, which resumes at the same bit.
// - While paused: output floats, clock and data input ignored.
// - Array is 512 pages of 256 bytes; address splits page/offset.
// - One write command stores one byte or up to 256 bytes.
// - Write programming is self-timed, at most 3 ms.
// - Works in clock modes 0 and 3 only.
// - Writable identification page; once locked, writes are refused.
// - Read-only 128-bit unique id, returned by its own read command.
// - Protect upper quarter, half or whole array; blocked writes dropped.
// - All bytes travel most significant bit first.
// - Unknown opcode: ignore everything until deselect.
// - Pause begins only while the serial clock is low.
// - Deselect during pause resets the port and drops the transfer.
module sesp_core #(
    parameter TWR_CYCLES        = `SESP_TWR_CYC,
    // Arbitrary unique id value
    parameter [127:0] UID_VALUE = 128'h00112233445566778899AABBCCDDEEFF
) (
    // Clock and reset
    input  wire clk_i,
    input  wire reset_i,
    // Serial pins
    input  wire spi_cs_n_i,
    input  wire spi_sck_i,
    input  wire spi_mosi_i,
    input  wire spi_hold_n_i,
    input  wire spi_wp_n_i,
    output reg  spi_miso_o,
    output reg  spi_miso_oe_o,
    // Status
    output reg  wr_busy_o
);
    localparam [4:0] ST_OPC  = 5'h01;
    localparam [4:0] ST_ADDR = 5'h02;
    localparam [4:0] ST_DATA = 5'h04;
    localparam [4:0] ST_OUT  = 5'h08;
    localparam [4:0] ST_WAIT = 5'h10;

    // Pin synchronisers
    reg  [4:0] sync1;
    reg  [4:0] sync2;
    wire       cs_n   = sync2[0];
    wire       sck    = sync2[1];
    wire       mosi   = sync2[2];
    wire       hold_n = sync2[3];
    wire       wp_n   = sync2[4];

    always @(posedge clk_i) begin
        if (reset_i) begin
            sync1 <= 5'h18;
            sync2 <= 5'h18;
        end else begin
            sync1 <= {spi_wp_n_i, spi_hold_n_i, spi_mosi_i,
                      spi_sck_i, spi_cs_n_i};
            sync2 <= sync1;
        end
    end

    // Storage
    reg  [7:0]   mem  [0:`SESP_MEM_SZ-1];
    reg  [7:0]   idpg [0:`SESP_PAGE_SZ-1];
    reg  [7:0]   pbuf [0:`SESP_PAGE_SZ-1];
    reg  [255:0] pval;

    // Port state
    reg        sck_prev;
    reg        cs_prev;
    reg        paused;
    reg        armed;
    reg  [4:0] state;
    reg  [2:0] bit_cnt;
    reg  [6:0] in_sh;
    reg  [7:0] op;
    reg  [23:0] addr;
    reg  [1:0] abyte;
    reg        wel;
    reg        wr_pending;
    reg        wr_bad;
    reg  [7:0] sr_new;
    reg  [7:0] woff;
    reg  [8:0] wpage;
    reg  [7:0] out_sh;
    reg        drv;
    reg        push_v;
    reg  [15:0] push_d;
    reg        start_req;

    // Write cycle state
    reg  [31:0] tmr;
    reg  [8:0] cidx;
    reg  [7:0] cop;
    reg  [8:0] cpage;
    reg  [1:0] bp;
    reg        srwd;
    reg        locked;
    reg        cyc_done;

    wire        fifo_in_ready;
    wire        fifo_out_valid;
    wire [15:0] fifo_out_data;
    wire        committing = wr_busy_o & ~fifo_out_valid & ~cidx[8];

    wire sck_rise = ~paused & ~cs_n & ~sck_prev & sck;
    wire sck_fall = ~paused & ~cs_n & sck_prev & ~sck;
    wire cs_fall  = cs_prev & ~cs_n;
    wire cs_rise  = ~cs_prev & cs_n;
    wire [7:0] in_byte   = {in_sh, mosi};
    wire       byte_done = sck_rise & (bit_cnt == 3'h7);
    wire [7:0] status = {srwd, 3'h0, bp, wel, wr_busy_o};

    // Next read address: taken from the last address byte or advanced
    wire [23:0] rd_addr = state[1] ? {addr[15:0], in_byte} :
                                     addr + 24'h000001;
    reg  [7:0] rd_byte;
    always @* begin
        case (op)
            `SESP_OP_READ:  rd_byte = mem[rd_addr[16:0]];
            `SESP_OP_RDID:  rd_byte = idpg[rd_addr[7:0]];
            `SESP_OP_RDUID: rd_byte = UID_VALUE[
                                {~rd_addr[3:0], 3'h0} +: 8];
            `SESP_OP_RDLS:  rd_byte = {7'h00, locked};
            default:        rd_byte = status;
        endcase
    end

    // Block protection of the page being written
    reg page_prot;
    always @* begin
        case (bp)
            `SESP_BP_QUART: page_prot = (wpage[8:7] == 2'h3);
            `SESP_BP_HALF:  page_prot = wpage[8];
            `SESP_BP_ALL:   page_prot = 1'b1;
            default:        page_prot = 1'b0;
        endcase
    end

    reg allowed;
    always @* begin
        case (op)
            `SESP_OP_WRITE: allowed = ~page_prot;
            `SESP_OP_WRID:  allowed = ~locked;
            `SESP_OP_LID:   allowed = ~locked;
            `SESP_OP_WRSR:  allowed = ~(srwd & ~wp_n);
            default:        allowed = 1'b0;
        endcase
    end

    // Pause tracking
    always @(posedge clk_i) begin
        if (reset_i) begin
            paused <= 1'b0;
        end else if (cs_n) begin
            paused <= 1'b0;
        end else if (~sck) begin
            paused <= ~hold_n;
        end
    end

    // Serial command sequencer
    always @(posedge clk_i) begin
        if (reset_i) begin
            sck_prev   <= 1'b0;
            cs_prev    <= 1'b0;
            armed      <= 1'b0;
            state      <= ST_OPC;
            bit_cnt    <= 3'h0;
            in_sh      <= 7'h00;
            op         <= 8'h00;
            addr       <= 24'h000000;
            abyte      <= 2'h0;
            wel        <= 1'b0;
            wr_pending <= 1'b0;
            wr_bad     <= 1'b0;
            sr_new     <= 8'h00;
            woff       <= 8'h00;
            wpage      <= 9'h000;
            out_sh     <= 8'h00;
            drv        <= 1'b0;
            spi_miso_o <= 1'b0;
            spi_miso_oe_o <= 1'b0;
            push_v     <= 1'b0;
            push_d     <= 16'h0000;
            start_req  <= 1'b0;
        end else begin
            cs_prev   <= cs_n;
            push_v    <= 1'b0;
            start_req <= 1'b0;
            if (~paused) begin
                sck_prev <= sck;
            end
            if (cs_fall) begin
                armed <= 1'b1;
            end
            if (cyc_done) begin
                wel <= 1'b0;
            end
            spi_miso_oe_o <= ~cs_n & ~paused &
                (drv | (sck_fall & state[3]));
            if (cs_n) begin
                state      <= ST_OPC;
                bit_cnt    <= 3'h0;
                abyte      <= 2'h0;
                drv        <= 1'b0;
                wr_pending <= 1'b0;
                wr_bad     <= 1'b0;
                if (cs_rise) begin
                    start_req <= wr_pending & ~wr_bad & ~paused &
                        (bit_cnt == 3'h0) & wel & allowed &
                        ~wr_busy_o;
                end
            end else begin
                if (sck_fall & state[3]) begin
                    spi_miso_o <= out_sh[7];
                    out_sh     <= {out_sh[6:0], 1'b0};
                    drv        <= 1'b1;
                end
                if (sck_rise) begin
                    bit_cnt <= bit_cnt + 3'h1;
                    in_sh   <= in_byte[6:0];
                end
                if (byte_done) begin
                    case (state)
                        ST_OPC: begin
                            op <= in_byte;
                            if (~armed) begin
                                state <= ST_WAIT;
                            end else if (in_byte == `SESP_OP_RDSR) begin
                                out_sh <= status;
                                state  <= ST_OUT;
                            end else if (wr_busy_o) begin
                                state <= ST_WAIT;
                            end else begin
                                case (in_byte)
                                    `SESP_OP_WREN: begin
                                        wel   <= 1'b1;
                                        state <= ST_WAIT;
                                    end
                                    `SESP_OP_WRDI: begin
                                        wel   <= 1'b0;
                                        state <= ST_WAIT;
                                    end
                                    `SESP_OP_WRSR: state <= ST_DATA;
                                    `SESP_OP_LID: begin
                                        wr_pending <= 1'b1;
                                        state      <= ST_WAIT;
                                    end
                                    `SESP_OP_READ,
                                    `SESP_OP_WRITE,
                                    `SESP_OP_RDID,
                                    `SESP_OP_WRID,
                                    `SESP_OP_RDLS,
                                    `SESP_OP_RDUID: state <= ST_ADDR;
                                    default: state <= ST_WAIT;
                                endcase
                            end
                        end
                        ST_ADDR: begin
                            addr  <= rd_addr;
                            abyte <= abyte + 2'h1;
                            if (abyte == `SESP_ADDR_LAST) begin
                                if (op == `SESP_OP_WRITE ||
                                    op == `SESP_OP_WRID) begin
                                    wpage <= rd_addr[16:8];
                                    woff  <= rd_addr[7:0];
                                    state <= ST_DATA;
                                end else begin
                                    out_sh <= rd_byte;
                                    state  <= ST_OUT;
                                end
                            end
                        end
                        ST_DATA: begin
                            wr_pending <= 1'b1;
                            if (op == `SESP_OP_WRSR) begin
                                sr_new <= in_byte;
                                state  <= ST_WAIT;
                            end else begin
                                push_v <= 1'b1;
                                push_d <= {woff, in_byte};
                                woff   <= woff + 8'h01;
                                if (~fifo_in_ready) begin
                                    wr_bad <= 1'b1;
                                end
                            end
                        end
                        ST_OUT: begin
                            out_sh <= rd_byte;
                            if (op != `SESP_OP_RDSR) begin
                                addr <= rd_addr;
                            end
                        end
                        ST_WAIT: state <= ST_WAIT;
                        default: state <= ST_WAIT;
                    endcase
                end
            end
        end
    end

    // Received write bytes on their way to the page buffer
    sesp_fifo #(
        .WIDTH (16),
        .DEPTH (8),
        .AW    (3)
    ) u_fifo (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .in_valid_i  (push_v),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (push_d),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (~committing),
        .out_data_o  (fifo_out_data)
    );

    // Page buffer fill and commit
    always @(posedge clk_i) begin
        if (fifo_out_valid & ~committing) begin
            pbuf[fifo_out_data[15:8]] <= fifo_out_data[7:0];
        end
        if (committing & pval[cidx[7:0]]) begin
            if (cop == `SESP_OP_WRITE) begin
                mem[{cpage, cidx[7:0]}] <= pbuf[cidx[7:0]];
            end else if (cop == `SESP_OP_WRID) begin
                idpg[cidx[7:0]] <= pbuf[cidx[7:0]];
            end
        end
    end

    // Self-timed write cycle, independent of chip select
    always @(posedge clk_i) begin
        if (reset_i) begin
            wr_busy_o <= 1'b0;
            tmr       <= 32'h00000000;
            cidx      <= 9'h000;
            cop       <= 8'h00;
            cpage     <= 9'h000;
            bp        <= `SESP_BP_NONE;
            srwd      <= 1'b0;
            locked    <= 1'b0;
            cyc_done  <= 1'b0;
            pval      <= {256{1'b0}};
        end else begin
            cyc_done <= 1'b0;
            if (fifo_out_valid & ~committing) begin
                pval[fifo_out_data[15:8]] <= 1'b1;
            end
            if (cs_fall & ~wr_busy_o) begin
                pval <= {256{1'b0}};
            end
            if (start_req) begin
                wr_busy_o <= 1'b1;
                tmr       <= 32'h00000000;
                cidx      <= 9'h000;
                cop       <= op;
                cpage     <= wpage;
            end else if (wr_busy_o) begin
                tmr <= tmr + 32'h00000001;
                if (committing) begin
                    cidx <= cidx + 9'h001;
                end
                if (tmr == TWR_CYCLES - 1) begin
                    wr_busy_o <= 1'b0;
                    cyc_done  <= 1'b1;
                    pval      <= {256{1'b0}};
                    if (cop == `SESP_OP_WRSR) begin
                        bp   <= sr_new[`SESP_SR_BP_HI:`SESP_SR_BP_LO];
                        srwd <= sr_new[`SESP_SR_SRWD];
                    end
                    if (cop == `SESP_OP_LID) begin
                        locked <= 1'b1;
                    end
                end
            end
        end
    end
endmodule // sesp_core

// file: hdl/sesp_regs.vh
// Constants of the serial EEPROM slave front end.
// Included by the core; definitions only.
`ifndef SESP_REGS_VH
`define SESP_REGS_VH

// Instruction codes
`define SESP_OP_WRSR   8'h01
`define SESP_OP_WRITE  8'h02
`define SESP_OP_READ   8'h03
`define SESP_OP_WRDI   8'h04
`define SESP_OP_RDSR   8'h05
`define SESP_OP_WREN   8'h06
`define SESP_OP_RDID   8'h83
`define SESP_OP_WRID   8'h82
`define SESP_OP_RDLS   8'h87
`define SESP_OP_LID    8'h86
`define SESP_OP_RDUID  8'h85

// Status byte fields
`define SESP_SR_BUSY   0
`define SESP_SR_WEL    1
`define SESP_SR_BP_LO  2
`define SESP_SR_BP_HI  3
`define SESP_SR_SRWD   7

// Block protect codes
`define SESP_BP_NONE   2'h0
`define SESP_BP_QUART  2'h1
`define SESP_BP_HALF   2'h2
`define SESP_BP_ALL    2'h3

// Array organisation
`define SESP_PAGES     512
`define SESP_PAGE_SZ   256
`define SESP_MEM_SZ    131072
`define SESP_ADDR_LAST 2'h2

// Self-timed write cycle
`define SESP_TWR_NS    3000000
`define SESP_CLK_MHZ   50
`define SESP_TWR_CYC   (`SESP_TWR_NS * `SESP_CLK_MHZ / 1000)

`endif

// file: hdl/sesp_fifo.v
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module sesp_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // Clock and reset
    input  wire             clk_i,
    input  wire             reset_i,
    // Fill side
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    // Drain side
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] store [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;

    wire push = in_valid_i & in_ready_o;
    wire pop  = out_valid_o & out_ready_i;

    assign in_ready_o  = (count != DEPTH[AW:0]);
    assign out_valid_o = (count != {(AW+1){1'b0}});
    assign out_data_o  = store[rd_ptr];

    always @(posedge clk_i) begin
        if (push) begin
            store[wr_ptr] <= in_data_i;
        end
    end

    always @(posedge clk_i) begin
        if (reset_i) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ?
                          {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ?
                          {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push & ~pop) begin
                count <= count + 1'b1;
            end else if (pop & ~push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // sesp_fifo

// file: test/sesp_core_checker.sv
// Checker of the serial slave core, bound to its ports.
// Assumes pins change off the rising clk edge.
`timescale 1ns/1ns
module sesp_core_checker #(
    parameter TWR_CYCLES = 150000
) (
    // Clock and reset
    input wire clk_i,
    input wire reset_i,
    // Serial pins
    input wire spi_cs_n_i,
    input wire spi_sck_i,
    input wire spi_mosi_i,
    input wire spi_hold_n_i,
    input wire spi_wp_n_i,
    input wire spi_miso_o,
    input wire spi_miso_oe_o,
    // Status
    input wire wr_busy_o
);
    reg [31:0] run  = 32'h0;
    reg        cs_q = 1'b1;
    reg        seen = 1'b0;
    // Busy run length and first select fall
    always @(posedge clk_i) begin
        cs_q <= spi_cs_n_i;
        if (reset_i) begin
            run  <= 32'h0;
            seen <= 1'b0;
        end else begin
            run  <= wr_busy_o ? run + 32'h1 : 32'h0;
            seen <= seen | (cs_q & ~spi_cs_n_i);
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    cs_float_a: assert property (spi_cs_n_i [*5] |-> !spi_miso_oe_o)
        else $error("output driven while deselected");
    pause_float_a: assert property (
        (!spi_hold_n_i && !spi_sck_i) [*6] |-> !spi_miso_oe_o)
        else $error("output driven while paused");
    miso_edge_a: assert property (
        spi_miso_oe_o && $changed(spi_miso_o)
        |-> !$past(spi_sck_i) && !$past(spi_sck_i, 2))
        else $error("output changed outside low clock phase");
    oe_rise_a: assert property (
        $rose(spi_miso_oe_o) |-> !spi_cs_n_i && spi_hold_n_i)
        else $error("output enabled without selection");
    oe_fall_a: assert property (
        $fell(spi_miso_oe_o) |-> spi_cs_n_i || !spi_hold_n_i)
        else $error("output released during transfer");
    busy_len_a: assert property (
        $fell(wr_busy_o) |-> run == TWR_CYCLES)
        else $error("write cycle length wrong");
    busy_start_a: assert property ($rose(wr_busy_o) |-> spi_cs_n_i)
        else $error("write cycle started while selected");
    no_first_a: assert property (
        !seen |-> !spi_miso_oe_o && !wr_busy_o)
        else $error("activity before first select fall");
endmodule // sesp_core_checker

bind sesp_core sesp_core_checker #(.TWR_CYCLES(TWR_CYCLES)) u_chk (
    .clk_i(clk_i), .reset_i(reset_i), .spi_cs_n_i(spi_cs_n_i),
    .spi_sck_i(spi_sck_i), .spi_mosi_i(spi_mosi_i),
    .spi_hold_n_i(spi_hold_n_i), .spi_wp_n_i(spi_wp_n_i),
    .spi_miso_o(spi_miso_o), .spi_miso_oe_o(spi_miso_oe_o),
    .wr_busy_o(wr_busy_o));

// file: test/sesp_spi_master.sv
// Serial bus master model: 160 ns serial clock, modes 0 and 3.
// Assumes a 50 MHz clk_i; all pins change at falling clk edges.
`timescale 1ns/1ns
module sesp_spi_master (
    // Clock
    input  wire clk_i,
    // From the slave
    input  wire miso_i,
    input  wire miso_oe_i,
    // To the slave
    output reg  cs_n_o   = 1'b1,
    output reg  sck_o    = 1'b0,
    output reg  mosi_o   = 1'b0,
    output reg  hold_n_o = 1'b1,
    output reg  wp_n_o   = 1'b1
);
    reg     mode3    = 1'b0;
    reg     abort    = 1'b0;
    reg     last     = 1'b0;
    integer pause_at = -1;
    integer nbit     = 0;
    // Floating line shows the flipped last value
    wire    line = miso_oe_i ? miso_i : ~last;
    always @(posedge clk_i) if (miso_oe_i) last <= miso_i;
    task wt(input integer n);
        repeat (n) @(negedge clk_i);
    endtask
    task sel;
        begin
            sck_o = mode3;
            wt(4);
            cs_n_o = 1'b0;
            nbit = 0;
            wt(4);
        end
    endtask
    task desel;
        begin
            sck_o = mode3;
            wt(4);
            cs_n_o = 1'b1;
            mosi_o = ~mosi_o;
            wt(8);
        end
    endtask
    task hold;
        begin
            hold_n_o = 1'b0;
            wt(8);
            repeat (3) begin
                sck_o = ~sck_o;
                mosi_o = ~mosi_o;
                wt(3);
            end
            sck_o = 1'b0;
            wt(3);
            if (abort) begin
                cs_n_o = 1'b1;
                wt(6);
            end
            hold_n_o = 1'b1;
            wt(3);
        end
    endtask
    // One byte each way; wp is never touched inside a frame
    task xb(input [7:0] d, output [7:0] r);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                sck_o = 1'b0;
                if (nbit == pause_at) hold;
                mosi_o = d[i];
                wt(5);
                r[i] = line;
                sck_o = 1'b1;
                wt(3);
                nbit = nbit + 1;
            end
        end
    endtask
endmodule // sesp_spi_master

// file: test/spi_eeprom_serial_port_bench.sv
// Self-checking bench of the serial EEPROM slave core.
// Assumes the master model and the bound checker are compiled first.
`timescale 1ns/1ns
`include "sesp_regs.vh"
module spi_eeprom_serial_port_bench;
    localparam TWR = 400;
    // Arbitrary unique id value
    localparam [127:0] UID = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
    reg        clk_i   = 1'b0;
    reg        reset_i = 1'b1;
    reg        oe_hit  = 1'b0;
    wire       cs_n, sck, mosi, hold_n, wp_n, miso, oe, busy;
    integer    n_fail  = 0;
    integer    n_tests = 0;
    integer    i, k;
    reg [7:0]  rd [0:7];
    reg [7:0]  wd [0:7];
    reg [7:0]  q;
    reg [23:0] a;
    initial forever #10 clk_i = ~clk_i;
    always @(posedge clk_i) if (oe) oe_hit <= 1'b1;
    sesp_core #(.TWR_CYCLES(TWR), .UID_VALUE(UID)) dut (
        .clk_i(clk_i), .reset_i(reset_i), .spi_cs_n_i(cs_n),
        .spi_sck_i(sck), .spi_mosi_i(mosi), .spi_hold_n_i(hold_n),
        .spi_wp_n_i(wp_n), .spi_miso_o(miso), .spi_miso_oe_o(oe),
        .wr_busy_o(busy));
    sesp_spi_master m (.clk_i(clk_i), .miso_i(miso), .miso_oe_i(oe),
        .cs_n_o(cs_n), .sck_o(sck), .mosi_o(mosi), .hold_n_o(hold_n),
        .wp_n_o(wp_n));
    task end_sim;
        begin
            $display("Checks %0d, mismatches %0d", n_tests, n_fail);
            if (n_fail == 0 && n_tests > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    task chk(input [7:0] got, input [7:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("BAD t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task wbusy(input integer exp);
        integer t;
        begin
            t = 0;
            while (busy !== 1'b1 && t < 40) begin
                @(negedge clk_i);
                t = t + 1;
            end
            if (exp < 2) chk({7'h00, busy === 1'b1}, exp[7:0]);
            t = 0;
            while (busy !== 1'b0 && t < TWR + 40) begin
                @(negedge clk_i);
                t = t + 1;
            end
            if (t >= TWR + 40) begin
                n_fail = n_fail + 1;
                end_sim;
            end
        end
    endtask
    task cmd(input [7:0] op, input [23:0] ad, input use_a);
        begin
            m.sel;
            m.xb(op, q);
            if (use_a) begin
                m.xb(ad[23:16], q);
                m.xb(ad[15:8], q);
                m.xb(ad[7:0], q);
            end
        end
    endtask
    task op1(input [7:0] op);
        begin
            cmd(op, 24'h0, 1'b0);
            m.desel;
        end
    endtask
    task wr(input [7:0] op, input [23:0] ad, input integer n);
        begin
            op1(`SESP_OP_WREN);
            cmd(op, ad, 1'b1);
            for (k = 0; k < n; k = k + 1) m.xb(wd[k], q);
            m.desel;
        end
    endtask
    task rdn(input [7:0] op, input [23:0] ad, input integer n);
        begin
            cmd(op, ad, 1'b1);
            for (k = 0; k < n; k = k + 1) m.xb(8'h00, rd[k]);
            m.desel;
        end
    endtask
    task sr_w(input [7:0] v);
        begin
            op1(`SESP_OP_WREN);
            cmd(`SESP_OP_WRSR, 24'h0, 1'b0);
            m.xb(v, q);
            m.desel;
        end
    endtask
    task rdsr;
        begin
            cmd(`SESP_OP_RDSR, 24'h0, 1'b0);
            m.xb(8'h00, q);
            m.desel;
        end
    endtask
    initial begin
        void'($urandom(32'h3353));
        m.cs_n_o = 1'b0;
        repeat (20) @(negedge clk_i);
        reset_i = 1'b0;
        m.xb(`SESP_OP_WREN, q);
        m.desel;
        rdsr;
        chk(q & 8'h02, 8'h00);
        op1(`SESP_OP_WREN);
        rdsr;
        chk(q & 8'h02, 8'h02);
        $display("Test select and enable done");
        sr_w(8'h84);
        wbusy(1);
        rdsr;
        chk(q & 8'h8C, 8'h84);
        m.wp_n_o = 1'b0;
        sr_w(8'h00);
        wbusy(0);
        m.wp_n_o = 1'b1;
        sr_w(8'h04);
        wbusy(1);
        a = $urandom;
        a[16:15] = 2'h3;
        wd[0] = $urandom;
        wr(`SESP_OP_WRITE, a, 1);
        wbusy(0);
        $display("Test protection done");
        a = $urandom;
        a[16] = 1'b0;
        a[7:0] = 8'hFC;
        for (i = 0; i < 8; i = i + 1) wd[i] = $urandom;
        wr(`SESP_OP_WRITE, a, 8);
        wbusy(1);
        m.pause_at = 45;
        rdn(`SESP_OP_READ, a ^ 24'hFE0000, 4);
        m.pause_at = -1;
        for (i = 0; i < 4; i = i + 1) chk(rd[i], wd[i]);
        rdn(`SESP_OP_READ, {a[23:8], 8'h00}, 4);
        for (i = 0; i < 4; i = i + 1) chk(rd[i], wd[i + 4]);
        wd[0] = $urandom;
        wr(`SESP_OP_WRITE, a, 1);
        wbusy(1);
        m.mode3 = 1'b1;
        rdn(`SESP_OP_READ, a, 1);
        m.mode3 = 1'b0;
        chk(rd[0], wd[0]);
        $display("Test page write and read done");
        m.abort = 1'b1;
        for (i = 36; i <= 40; i = i + 4) begin
            m.pause_at = i;
            wr(`SESP_OP_WRITE, a, 2);
            wbusy(0);
        end
        m.abort = 1'b0;
        m.pause_at = -1;
        oe_hit = 1'b0;
        rdn(8'hFF, 24'h030000, 1);
        chk({7'h00, oe_hit}, 8'h00);
        $display("Test abort and bad opcode done");
        i = $urandom % 16;
        rdn(`SESP_OP_RDUID, i[23:0], 1);
        chk(rd[0], UID[127 - 8 * i -: 8]);
        a = $urandom % 256;
        wd[0] = $urandom;
        wr(`SESP_OP_WRID, a, 1);
        wbusy(1);
        op1(`SESP_OP_WREN);
        op1(`SESP_OP_LID);
        wbusy(2);
        rdn(`SESP_OP_RDLS, 24'h0, 1);
        chk(rd[0], 8'h01);
        wd[0] = ~wd[0];
        wr(`SESP_OP_WRID, a, 1);
        wbusy(0);
        rdn(`SESP_OP_RDID, a, 1);
        chk(rd[0], ~wd[0]);
        $display("Test id page and unique id done");
        end_sim;
    end
endmodule // spi_eeprom_serial_port_bench
